//--- dscp_consts.vh
// Behaviour
// - Top selector bits pick output pin source
// - Status selection overrides 4-wire read data
// - Four-wire bit switches 3-wire/4-wire operation
// - 3-wire shares data pin; 4-wire splits pins
// - Sample on rising, change on falling
// - Instruction bit 7: read high, write low
// - Instruction bits 6:5 give byte count minus one
// - All bytes shift most significant first
// - Bits 4:0 start address, counts down
// - 3-wire reads drive data pin; output floats unless a status code or the undefined code is selected
// - 4-wire: low after last bit, then release
// - 16-bit word captured on both clock edges
// - Clock edges shifted against data for timing; here lanes are sampled on the core edge that first sees the data clock move
// - Sync low zeros data; rising edge syncs
// - Sync lane buffered alongside the data
`ifndef DSCP_CONSTS_VH
`define DSCP_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define DSCP_IFCFG_ADDR 5'h05
`define DSCP_OUTSEL_ADDR 5'h0e
`define DSCP_SPARE_ADDR 5'h0f
`define DSCP_STATUS_ADDR 5'h15
`define DSCP_REG_RESET 8'h00
`define DSCP_FOUR_WIRE_BIT 6
`define DSCP_SEL_MSB 7
`define DSCP_SEL_LSB 5

// ****************************************
// Output pin source codes
// ****************************************
`define DSCP_SEL_NORMAL0 3'h0
`define DSCP_SEL_UNDEF 3'h1
`define DSCP_SEL_LOCK 3'h2
`define DSCP_SEL_PATTERN 3'h3
`define DSCP_SEL_FIFO 3'h4
`define DSCP_SEL_SELFTEST 3'h5

// ****************************************
// Instruction byte and status fields
// ****************************************
`define DSCP_INSTR_RW_BIT 7
`define DSCP_INSTR_CNT_MSB 6
`define DSCP_INSTR_CNT_LSB 5
`define DSCP_INSTR_ADDR_MSB 4
`define DSCP_ST_LOCK_BIT 0
`define DSCP_ST_PATTERN_BIT 1
`define DSCP_ST_FIFO_BIT 2
`define DSCP_ST_SELFTEST_BIT 3
`define DSCP_ST_OVF_BIT 4

`endif

//--- dscp_serial_port.v
`timescale 1ns/1ps
`include "dscp_consts.vh"

module dscp_serial_port (
   input wire core_clk_i,
   input wire rstn_i,
   input wire sclk_i,
   input wire frame_enable_n_i,
   input wire sdio_i,
   output wire sdio_o,
   output wire sdio_oe_n_o,
   output wire sdo_o,
   output wire sdo_oe_n_o,
   input wire dll_lock_i,
   input wire pattern_err_i,
   input wire self_test_error_i,
   input wire half_rate_data_clock_i,
   input wire [15:0] lvds_data_i,
   input wire sync_enable_lane_i,
   output wire buf_in_ready_o,
   output wire [15:0] sample_o,
   output wire sample_valid_o,
   input wire sample_ready_i,
   output wire sync_event_o
);

   // ****************************************
   // States and helpers
   // ****************************************
   // One frame walks instruction, then write or read bytes, then waits in done
   // until the enable rises; an early rise always returns to instruction
   localparam [3:0] ST_INSTR = 4'h1;
   localparam [3:0] ST_WDATA = 4'h2;
   localparam [3:0] ST_RDATA = 4'h4;
   localparam [3:0] ST_DONE = 4'h8;

   // Status code check used by the output pin path only
   function is_status_sel;
      input [2:0] sel;
      begin
         is_status_sel = (sel >= `DSCP_SEL_LOCK) && (sel <= `DSCP_SEL_SELFTEST);
      end
   endfunction

   // Eighth bit of a byte; byte boundaries are decided in several places
   function is_last_bit;
      input [2:0] cnt;
      begin
         is_last_bit = (cnt == 3'h7);
      end
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg [2:0] sclk_sync_reg;
   reg [1:0] fen_sync_reg;
   reg [1:0] sdio_sync_reg;
   reg [2:0] dclk_sync_reg;
   reg [16:0] lane_s1_reg;
   reg [16:0] lane_s2_reg;

   // Two flops per pin; the third sclk/dclk stage exists only for edge finding.
   // Edge detection costs two to three core cycles, so the serial clock must
   // stay at least eight core cycles per bit for the read path to keep up.
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_sync_reg <= 3'h0;
         fen_sync_reg <= 2'h3;
         sdio_sync_reg <= 2'h0;
         dclk_sync_reg <= 3'h0;
         lane_s1_reg <= 17'h00000;
         lane_s2_reg <= 17'h00000;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
         fen_sync_reg <= {fen_sync_reg[0], frame_enable_n_i};
         sdio_sync_reg <= {sdio_sync_reg[0], sdio_i};
         dclk_sync_reg <= {dclk_sync_reg[1:0], half_rate_data_clock_i};
         lane_s1_reg <= {sync_enable_lane_i, lvds_data_i};
         lane_s2_reg <= lane_s1_reg;
      end
   end

   wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
   wire frame_off = fen_sync_reg[1];
   wire din = sdio_sync_reg[1];

   // ****************************************
   // Register file
   // ****************************************
   // Every address is plain storage except the live status byte; reserved
   // fields are stored as written, keeping them zero is the host's duty
   reg [7:0] regs_reg [0:31];
   reg ovf_reg;
   wire four_wire = regs_reg[`DSCP_IFCFG_ADDR][`DSCP_FOUR_WIRE_BIT];
   wire [2:0] sel = regs_reg[`DSCP_OUTSEL_ADDR][`DSCP_SEL_MSB:`DSCP_SEL_LSB];
   wire [7:0] status_val = {3'h0, ovf_reg, self_test_error_i, ovf_reg, pattern_err_i,
      dll_lock_i};

   // Read side returns live status at the status address
   function [7:0] reg_read;
      input [4:0] a;
      input [7:0] st;
      input [7:0] stored;
      begin
         reg_read = (a == `DSCP_STATUS_ADDR) ? st : stored;
      end
   endfunction

   // ****************************************
   // Serial frame engine
   // ****************************************
   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [7:0] rx_shift_reg;
   reg [7:0] tx_shift_reg;
   reg [2:0] bit_cnt_reg;
   reg [1:0] bytes_left_reg;
   reg [4:0] addr_reg;
   reg is_read_reg;
   reg tx_bit_reg;
   reg wr_en;
   reg [7:0] wr_data;
   wire [7:0] rx_byte = {rx_shift_reg[6:0], din};
   wire [7:0] tx_src = (bit_cnt_reg == 3'h0) ?
      reg_read(addr_reg, status_val, regs_reg[addr_reg]) : tx_shift_reg;

   // Next state; a frame that ends early keeps the bytes already written and drops the partial one
   always @* begin
      state_next = state_reg;
      wr_en = 1'b0;
      wr_data = rx_byte;
      if (frame_off) begin
         state_next = ST_INSTR;
      end else begin
         case (state_reg)
            ST_INSTR: begin
               if (sclk_rise && is_last_bit(bit_cnt_reg)) begin
                  state_next = rx_byte[`DSCP_INSTR_RW_BIT] ? ST_RDATA : ST_WDATA;
               end
            end
            ST_WDATA: begin
               // Write lands on the last rising edge of each data byte
               if (sclk_rise && is_last_bit(bit_cnt_reg)) begin
                  wr_en = 1'b1;
                  if (bytes_left_reg == 2'h0) begin
                     state_next = ST_DONE;
                  end
               end
            end
            ST_RDATA: begin
               // Last bit goes out on this fall; the next fall drives low
               if (sclk_fall && is_last_bit(bit_cnt_reg) && bytes_left_reg == 2'h0) begin
                  state_next = ST_DONE;
               end
            end
            ST_DONE: begin
               state_next = ST_DONE;
            end
            default: begin
               state_next = ST_INSTR;
            end
         endcase
      end
   end

   // Shifting, counting and address walk.
   // Read bytes are fetched at the first fall of each byte, so a status
   // change during the byte shows only in a later read of the status address.
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= ST_INSTR;
         rx_shift_reg <= 8'h00;
         tx_shift_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         bytes_left_reg <= 2'h0;
         addr_reg <= 5'h00;
         is_read_reg <= 1'b0;
         tx_bit_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (frame_off) begin
            bit_cnt_reg <= 3'h0;
            is_read_reg <= 1'b0;
            tx_bit_reg <= 1'b0;
         end else if (state_reg == ST_INSTR || state_reg == ST_WDATA) begin
            if (sclk_rise) begin
               rx_shift_reg <= rx_byte;
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == 3'h7 && state_reg == ST_INSTR) begin
                  is_read_reg <= rx_byte[`DSCP_INSTR_RW_BIT];
                  bytes_left_reg <= rx_byte[`DSCP_INSTR_CNT_MSB:`DSCP_INSTR_CNT_LSB];
                  addr_reg <= rx_byte[`DSCP_INSTR_ADDR_MSB:0];
               end else if (bit_cnt_reg == 3'h7) begin
                  addr_reg <= addr_reg - 5'h01;
                  bytes_left_reg <= bytes_left_reg - 2'h1;
               end
            end
         end else if (state_reg == ST_RDATA) begin
            if (sclk_fall) begin
               tx_bit_reg <= tx_src[7];
               tx_shift_reg <= {tx_src[6:0], 1'b0};
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == 3'h7) begin
                  addr_reg <= addr_reg - 5'h01;
                  bytes_left_reg <= bytes_left_reg - 2'h1;
               end
            end
         end else if (state_reg == ST_DONE && sclk_fall) begin
            tx_bit_reg <= 1'b0;
         end
      end
   end

   // Register writes; only the status address is not storage the host can alter
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_regs
         always @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               regs_reg[gi] <= `DSCP_REG_RESET;
            end else if (wr_en && addr_reg == gi && gi != `DSCP_STATUS_ADDR) begin
               regs_reg[gi] <= wr_data;
            end
         end
      end
   endgenerate

   // ****************************************
   // Output pin drivers
   // ****************************************
   reg sdio_oe_n_reg;
   reg sdo_reg;
   reg sdo_oe_n_reg;
   wire rd_phase = is_read_reg && !frame_off &&
      (state_reg == ST_RDATA || state_reg == ST_DONE);

   // Status mux; registered so the pins never glitch on selector changes.
   // A status selection drives the output pin in both modes, so in
   // four-wire mode read data is lost while a status code is selected.
   // The undefined code drives low rather than leaving the pin floating.
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sdio_oe_n_reg <= 1'b1;
         sdo_reg <= 1'b0;
         sdo_oe_n_reg <= 1'b1;
      end else begin
         sdio_oe_n_reg <= ~(rd_phase && !four_wire);
         if (is_status_sel(sel)) begin
            sdo_oe_n_reg <= 1'b0;
            case (sel)
               `DSCP_SEL_LOCK: sdo_reg <= dll_lock_i;
               `DSCP_SEL_PATTERN: sdo_reg <= pattern_err_i;
               `DSCP_SEL_FIFO: sdo_reg <= ovf_reg;
               default: sdo_reg <= self_test_error_i;
            endcase
         end else if (sel == `DSCP_SEL_UNDEF) begin
            sdo_oe_n_reg <= 1'b0;
            sdo_reg <= 1'b0;
         end else begin
            sdo_oe_n_reg <= ~(rd_phase && four_wire);
            sdo_reg <= tx_bit_reg;
         end
      end
   end

   // Pin values and enables; enables are low while driving
   assign sdio_o = tx_bit_reg;
   assign sdio_oe_n_o = sdio_oe_n_reg;
   assign sdo_o = sdo_reg;
   assign sdo_oe_n_o = sdo_oe_n_reg;

   // ****************************************
   // Sample capture and two-entry buffer
   // ****************************************
   // Two entries let the consumer stall for one word without loss;
   // a longer stall overflows and is reported in the status byte
   reg [15:0] buf_reg [0:1];
   reg wr_ptr_reg;
   reg rd_ptr_reg;
   reg [1:0] count_reg;
   reg sync_prev_reg;
   reg sync_event_reg;
   // Both clock edges carry a word; the extra edge-finding flop only finds the edge and does not delay the lanes.
   // This stands in for the delay loop: lanes are sampled on the same core edge
   // that first sees the data clock move, well inside the word's valid window.
   // The data clock must stay at least two core cycles per half period.
   wire dclk_edge = dclk_sync_reg[1] ^ dclk_sync_reg[2];
   wire lane_sync = lane_s2_reg[16];
   wire [15:0] lane_word = lane_sync ? lane_s2_reg[15:0] : 16'h0000;
   wire in_ready = (count_reg != 2'h2);
   wire push = dclk_edge && in_ready;
   wire pop = (count_reg != 2'h0) && sample_ready_i;

   // The source cannot be stalled, so a word arriving while full is counted as lost
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         buf_reg[0] <= 16'h0000;
         buf_reg[1] <= 16'h0000;
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
         sync_prev_reg <= 1'b0;
         sync_event_reg <= 1'b0;
         ovf_reg <= 1'b0;
      end else begin
         sync_event_reg <= 1'b0;
         if (push) begin
            buf_reg[wr_ptr_reg] <= lane_word;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
         if (dclk_edge) begin
            sync_prev_reg <= lane_sync;
            sync_event_reg <= lane_sync & ~sync_prev_reg;
         end
         // Overflow set wins over a clear written in the same cycle
         if (dclk_edge && !in_ready) begin
            ovf_reg <= 1'b1;
         end else if (wr_en && addr_reg == `DSCP_STATUS_ADDR &&
               !wr_data[`DSCP_ST_OVF_BIT]) begin
            ovf_reg <= 1'b0;
         end
      end
   end

   // Buffer head and flags; valid follows the count, never the pointers
   assign buf_in_ready_o = in_ready;
   assign sample_o = buf_reg[rd_ptr_reg];
   assign sample_valid_o = (count_reg != 2'h0);
   assign sync_event_o = sync_event_reg;

endmodule // dscp_serial_port

//--- dscp_host_model.sv
`timescale 1ns/1ps
module dscp_host_model (
   input wire logic rx_i,
   output logic sclk_o,
   output logic frame_enable_n_o,
   output logic sdio_drv_o,
   output logic sdio_en_o
);
   // Serial clock rests low and the enable high between frames
   initial begin
      sclk_o = 1'b0;
      frame_enable_n_o = 1'b1;
      sdio_drv_o = 1'b0;
      sdio_en_o = 1'b0;
   end

   // One frame at a 200 ns bit period; the low phase is longer because
   // read bits appear a few core cycles after each fall
   task automatic xfer(input logic [7:0] ins, input logic [31:0] wd, output logic [31:0] rd);
      logic [39:0] sh;
      int nb;
      sh = {ins, wd};
      nb = 8 * (ins[6:5] + 2);
      rd = 32'h0;
      #7 frame_enable_n_o = 1'b0;
      for (int i = 0; i < nb; i++) begin
         sdio_en_o = i < 8 || !ins[7];
         sdio_drv_o = sh[39 - i];
         #125 sclk_o = 1'b1;
         rd = {rd[30:0], rx_i};
         #75 sclk_o = 1'b0;
      end
      sdio_en_o = 1'b0;
      #125 frame_enable_n_o = 1'b1;
      #200;
   endtask
endmodule // dscp_host_model

//--- dscp_serial_port_props.sv
`timescale 1ns/1ps
module dscp_serial_port_props (
   input wire core_clk_i,
   input wire rstn_i,
   input wire sclk_i,
   input wire frame_enable_n_i,
   input wire sdio_o,
   input wire sdio_oe_n_o,
   input wire sdo_oe_n_o,
   input wire half_rate_data_clock_i,
   input wire buf_in_ready_o,
   input wire [15:0] sample_o,
   input wire sample_valid_o,
   input wire sample_ready_i,
   input wire sync_event_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);
   reg [2:0] fall_age_reg;

   // Cycles since the serial clock fell; saturates so it never wraps
   always @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) fall_age_reg <= 3'h7;
      else if ($fell(sclk_i)) fall_age_reg <= 3'h0;
      else if (fall_age_reg != 3'h7) fall_age_reg <= fall_age_reg + 3'h1;
   end

   // ****************************************
   // Properties
   // ****************************************
   reset_idle_a: assert property ($rose(rstn_i) |-> sdio_oe_n_o && sdo_oe_n_o
      && !sample_valid_o && buf_in_ready_o && !sync_event_o) else $error("not idle after reset");
   drive_in_frame_a: assert property ($fell(sdio_oe_n_o) |-> !frame_enable_n_i)
      else $error("data pin driven outside a frame");
   pin_release_a: assert property ($rose(frame_enable_n_i) |-> ##[0:5] sdio_oe_n_o)
      else $error("data pin not released");
   bit_on_fall_a: assert property (!sdio_oe_n_o && $changed(sdio_o) |-> fall_age_reg <= 3'h6)
      else $error("read bit changed away from a falling edge");
   edge_push_a: assert property ($changed(half_rate_data_clock_i) && !sample_valid_o
      |-> ##[1:6] sample_valid_o) else $error("word not captured");
   stall_hold_a: assert property (sample_valid_o && !sample_ready_i
      |=> sample_valid_o && $stable(sample_o)) else $error("word lost under stall");
   full_nonempty_a: assert property (!buf_in_ready_o |-> sample_valid_o)
      else $error("full buffer shows no word");
   sync_pulse_a: assert property (sync_event_o |=> !sync_event_o)
      else $error("sync event longer than one cycle");
   cover property (!sdio_oe_n_o);
   cover property (!buf_in_ready_o);
   cover property (sync_event_o);
endmodule // dscp_serial_port_props

bind dscp_serial_port dscp_serial_port_props u_props (.core_clk_i, .rstn_i, .sclk_i,
   .frame_enable_n_i, .sdio_o, .sdio_oe_n_o, .sdo_oe_n_o, .half_rate_data_clock_i,
   .buf_in_ready_o, .sample_o, .sample_valid_o, .sample_ready_i, .sync_event_o);

//--- dscp_serial_port_tb_top.sv
`timescale 1ns/1ps
module dscp_serial_port_tb_top;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic lock_i = 1'b0, patt_i = 1'b0, self_i = 1'b0, dclk_i = 1'b0, sync_i = 1'b0;
   logic ready_i = 1'b0, four = 1'b0;
   logic [15:0] lane_i = 16'h0000;
   logic sclk, fen_n, h_d, h_en;
   wire sdio_o, sdio_oe_n_o, sdo_o, sdo_oe_n_o, buf_in_ready_o, sample_valid_o, sync_event_o;
   wire [15:0] sample_o;
   int n_mismatch = 0, check_count = 0, cyc = 0, n_sync = 0;
   // Pull-down holds the data pin low when nobody drives; a floating output pin toggles
   wire sdio_ln = !sdio_oe_n_o ? sdio_o : (h_en ? h_d : 1'b0);
   wire rx = four ? (sdo_oe_n_o ? core_clk_i : sdo_o) : sdio_ln;

   dscp_host_model host (.rx_i(rx), .sclk_o(sclk), .frame_enable_n_o(fen_n),
      .sdio_drv_o(h_d), .sdio_en_o(h_en));
   dscp_serial_port DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .sclk_i(sclk),
      .frame_enable_n_i(fen_n), .sdio_i(sdio_ln), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o),
      .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .dll_lock_i(lock_i), .pattern_err_i(patt_i),
      .self_test_error_i(self_i), .half_rate_data_clock_i(dclk_i), .lvds_data_i(lane_i),
      .sync_enable_lane_i(sync_i), .buf_in_ready_o(buf_in_ready_o), .sample_o(sample_o),
      .sample_valid_o(sample_valid_o), .sample_ready_i(ready_i), .sync_event_o(sync_event_o));

   always #12.5 core_clk_i = ~core_clk_i;

   // Count sync pulses; the cycle ceiling leaves about twice the expected run
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (sync_event_o === 1'b1) n_sync <= n_sync + 1;
      if (cyc == 9000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // ****************************************
   // Checking and frame tasks
   // ****************************************
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk_bit(input string what, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %b seen %b", what, e, g);
      end
   endtask
   task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   // Data for a write sits in the top bytes of wd
   task automatic wr(input logic [4:0] a, input logic [1:0] nm1, input logic [31:0] wd);
      logic [31:0] junk;
      @(negedge core_clk_i);
      host.xfer({1'b0, nm1, a}, wd, junk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [1:0] nm1, input logic [31:0] e);
      logic [31:0] got;
      @(negedge core_clk_i);
      host.xfer({1'b1, nm1, a}, 32'h0, got);
      chk_word("read data", e, got & ~(32'hffffffff << (8 * (nm1 + 1))));
   endtask
   // Lanes and sync settle two cycles before the data clock toggles
   task automatic push(input logic [15:0] w, input logic s);
      @(negedge core_clk_i);
      lane_i = w;
      sync_i = s;
      repeat (2) @(negedge core_clk_i);
      dclk_i = ~dclk_i;
      repeat (4) @(negedge core_clk_i);
   endtask
   task automatic pop();
      @(negedge core_clk_i);
      ready_i = 1'b1;
      @(negedge core_clk_i);
      ready_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // Burst write, then reads of several lengths walk addresses downwards
   task automatic t_burst();
      wr(5'h0f, 2'h0, 32'h0);
      rd(5'h0f, 2'h1, 32'h0);
      wr(5'h03, 2'h3, 32'ha1b2c3d4);
      rd(5'h03, 2'h3, 32'ha1b2c3d4);
      rd(5'h02, 2'h2, 32'hb2c3d4);
      wr(5'h01, 2'h0, 32'h5a000000);
      rd(5'h01, 2'h0, 32'h5a);
      chk_bit("data pin enable", 1'b1, sdio_oe_n_o);
   endtask
   // Consumer stalls: third word is refused, the two held ones drain in order
   task automatic t_stream();
      push(16'h1234, 1'b0);
      push(16'hbeef, 1'b1);
      push(16'h7777, 1'b1);
      chk_bit("buffer ready", 1'b0, buf_in_ready_o);
      chk_word("first word", 32'h0, {16'h0, sample_o});
      pop();
      chk_word("second word", 32'hbeef, {16'h0, sample_o});
      pop();
      chk_bit("word valid", 1'b0, sample_valid_o);
      chk_word("sync events", 32'h1, n_sync);
   endtask
   // Read in four-wire mode; output pin holds low until the enable rises
   task automatic t_four_wire();
      wr(5'h05, 2'h0, 32'h40000000);
      four = 1'b1;
      fork
         rd(5'h02, 2'h1, 32'hb25a);
         begin
            @(posedge fen_n);
            chk_word("out pin at end", 32'h0, {30'h0, sdo_oe_n_o, sdo_o});
         end
      join
      chk_bit("out pin enable", 1'b1, sdo_oe_n_o);
   endtask
   // Every selector code, with the lock, pattern and self-test levels flipped between passes; overflow stays set
   task automatic t_select();
      logic [5:0] lvl;
      for (int p = 0; p < 2; p++) begin
         @(negedge core_clk_i);
         lock_i = p[0];
         patt_i = !p[0];
         self_i = p[0];
         lvl = {self_i, 1'b1, patt_i, lock_i, 2'b00};
         for (int c = 0; c < 8; c++) begin
            wr(5'h0e, 2'h0, {c[2:0], 29'h0});
            chk_bit("out pin enable", c == 0 || c > 5, sdo_oe_n_o);
            if (c inside {[1:5]}) chk_bit("out pin level", lvl[c], sdo_o);
         end
      end
   endtask

   initial begin
      repeat (10) @(negedge core_clk_i);
      rstn_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      t_burst();
      t_stream();
      t_four_wire();
      t_select();
      finish_test();
   end
endmodule // dscp_serial_port_tb_top
